// [pkg/bcg_defs.vh]
// Constants for the commutation and drive-gating block
// Operation
// [R1] Each oscillator cycle start sets both the PWM latch and the current-limit latch.
// [R2] Ramp above speed command clears the PWM latch, ending bottom conduction this cycle.
// [R3] PWM gates only bottom drives; selected top drive stays on through the state.
// [R4] Current over threshold clears the lower latch at once until next cycle start.
// [R5] At most one conduction pulse per oscillator cycle, whichever event ends it.
// [R6] Top drives are active low; bottom drives are active high.
// [R7] Phasing select 1 uses the 60 degree table, 0 the 120 degree table.
// [R8] Forward, enabled, no limit: each valid code enables one top, one bottom, different phases.
// [R9] Invalid sensor code turns all top drives off and all bottom drives low.
// [R10] Enable low turns all drives off so the motor coasts, for any code.
// [R11] Current sense asserted with valid code and enable turns all drives off.
// [R12] Either undervoltage indication turns top drives off and holds bottoms low.
// [R13] Reverse direction swaps top and bottom enables of each phase.
// [R14] Enable defaults to running when unconnected, as if pulled up.
// [R15] Forward pairs A/C,B/C,B/A,C/A,C/B,A/B follow the listed sensor code orders.
// [R16] Codes 101 and 010 invalid at 60 degrees; 111 and 000 at 120 degrees.
`ifndef BCG_DEFS_VH
`define BCG_DEFS_VH
`define BCG_PH_A       2
`define BCG_PH_B       1
`define BCG_PH_C       0
`define BCG_TOP_OFF    3'h7
`define BCG_BOT_OFF    3'h0
`define BCG_SYNC_RST   3'h0
`define BCG_STEP_NONE  3'h7
`define BCG_SYNC_W     3
// Synchroniser reset values: only the enable bit (index 5) idles high
`define BCG_SYNC_RST_VEC 11'h020
`endif

// [src/bcg_sync.v]
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
module bcg_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk_sys_i,
    input  wire rstn_i,
    input  wire async_i,
    output reg  sync_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Only s2 and s3 are compared; s1 feeds s2 alone
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q   <= RST_VAL;
            s2_q   <= RST_VAL;
            s3_q   <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_o <= s3_q;
            end
        end
    end
endmodule

// [src/bcg_commutation_gate.v]
// Commutation decoder, dual-latch PWM gating and drive outputs
`timescale 1ns/1ns
`include "bcg_defs.vh"
module bcg_commutation_gate (
    input  wire clk_sys_i,
    input  wire rstn_i,
    input  wire rotor_sensor_a_i,
    input  wire rotor_sensor_b_i,
    input  wire rotor_sensor_c_i,
    input  wire phase_60_sel_i,
    input  wire forward_i,
    input  wire enable_i,
    input  wire osc_cycle_start_i,
    input  wire ramp_above_cmd_i,
    input  wire current_over_i,
    input  wire vcc_undervolt_i,
    input  wire ref_undervolt_i,
    output reg  top_drive_a_n_o,
    output reg  top_drive_b_n_o,
    output reg  top_drive_c_n_o,
    output reg  bottom_drive_a_o,
    output reg  bottom_drive_b_o,
    output reg  bottom_drive_c_o,
    output wire pwm_latch_o,
    output wire limit_latch_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: every input arrives from outside the clock domain
    localparam N_IN = 11;
    wire [N_IN-1:0] raw_w;
    wire [N_IN-1:0] syn_w;
    // Enable resets high so an idle pin reads as running [R14]
    localparam [N_IN-1:0] RST_VEC = `BCG_SYNC_RST_VEC;

    assign raw_w = {rotor_sensor_a_i, rotor_sensor_b_i, rotor_sensor_c_i, phase_60_sel_i,
                    forward_i, enable_i, osc_cycle_start_i, ramp_above_cmd_i,
                    current_over_i, vcc_undervolt_i, ref_undervolt_i};

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_sync
            bcg_sync #(
                .RST_VAL (RST_VEC[gi])
            ) u_sync (
                .clk_sys_i (clk_sys_i),
                .rstn_i    (rstn_i),
                .async_i   (raw_w[gi]),
                .sync_o    (syn_w[gi])
            );
        end
    endgenerate

    wire [2:0] code_w     = syn_w[10:8];
    wire       sel60_w    = syn_w[7];
    wire       fwd_w      = syn_w[6];
    wire       en_w       = syn_w[5];
    wire       start_w    = syn_w[4];
    wire       ramp_w     = syn_w[3];
    wire       cur_w      = syn_w[2];
    wire       uv_w       = syn_w[1] | syn_w[0];

    ////////////////////////////////////////////////////////////////////////
    // Rotor position decode to step index, 7 meaning invalid
    reg [2:0] step_w;
    always @* begin
        step_w = `BCG_STEP_NONE;
        if (sel60_w) begin // [R7]
            case (code_w) // [R15] [R16]
                3'h4:    step_w = 3'h0;
                3'h6:    step_w = 3'h1;
                3'h7:    step_w = 3'h2;
                3'h3:    step_w = 3'h3;
                3'h1:    step_w = 3'h4;
                3'h0:    step_w = 3'h5;
                default: step_w = `BCG_STEP_NONE;
            endcase
        end else begin
            case (code_w) // [R15] [R16]
                3'h4:    step_w = 3'h0;
                3'h6:    step_w = 3'h1;
                3'h2:    step_w = 3'h2;
                3'h3:    step_w = 3'h3;
                3'h1:    step_w = 3'h4;
                3'h5:    step_w = 3'h5;
                default: step_w = `BCG_STEP_NONE;
            endcase
        end
    end

    // One-hot phase selection, bit 2 = A, bit 0 = C
    reg [2:0] top_sel_w;
    reg [2:0] bot_sel_w;
    always @* begin
        top_sel_w = `BCG_BOT_OFF;
        bot_sel_w = `BCG_BOT_OFF;
        case (step_w) // [R8]
            3'h0: begin top_sel_w = 3'h4; bot_sel_w = 3'h1; end
            3'h1: begin top_sel_w = 3'h2; bot_sel_w = 3'h1; end
            3'h2: begin top_sel_w = 3'h2; bot_sel_w = 3'h4; end
            3'h3: begin top_sel_w = 3'h1; bot_sel_w = 3'h4; end
            3'h4: begin top_sel_w = 3'h1; bot_sel_w = 3'h2; end
            3'h5: begin top_sel_w = 3'h4; bot_sel_w = 3'h2; end
            default: begin top_sel_w = `BCG_BOT_OFF; bot_sel_w = `BCG_BOT_OFF; end
        endcase
        if (!fwd_w) begin // [R13]
            top_sel_w = top_sel_w ^ bot_sel_w;
            bot_sel_w = top_sel_w ^ bot_sel_w;
            top_sel_w = top_sel_w ^ bot_sel_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dual latch: both set at cycle start, each cleared by its own event
    reg pwm_q;
    reg lim_q;
    reg pwm_d;
    reg lim_d;
    always @* begin
        pwm_d = pwm_q;
        lim_d = lim_q;
        // Compare and limit win over a coincident start, so a pulse never restarts mid-cycle
        if (start_w) begin // [R1]
            pwm_d = 1'b1;
            lim_d = 1'b1;
        end
        if (ramp_w) begin // [R2]
            pwm_d = 1'b0;
        end
        if (cur_w) begin // [R4]
            lim_d = 1'b0;
        end
    end

    // Latches start off after reset until the first cycle start arrives
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_q <= 1'b0;
            lim_q <= 1'b0;
        end else begin
            pwm_q <= pwm_d; // [R5]
            lim_q <= lim_d; // [R5]
        end
    end

    assign pwm_latch_o   = pwm_q;
    assign limit_latch_o = lim_q;

    ////////////////////////////////////////////////////////////////////////
    // Drive output stage
    wire run_w  = en_w & ~uv_w & (step_w != `BCG_STEP_NONE); // [R9] [R10] [R12]
    // Current sense kills the tops at once; the lower latch also blocks the rest of the cycle
    wire live_w = run_w & ~cur_w & lim_q; // [R4] [R11]
    reg [2:0] top_on_w;
    reg [2:0] bot_on_w;
    always @* begin
        top_on_w = live_w ? top_sel_w : `BCG_BOT_OFF; // [R3]
        bot_on_w = (live_w & pwm_q) ? bot_sel_w : `BCG_BOT_OFF; // [R3]
    end

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {top_drive_a_n_o, top_drive_b_n_o, top_drive_c_n_o}    <= `BCG_TOP_OFF;
            {bottom_drive_a_o, bottom_drive_b_o, bottom_drive_c_o} <= `BCG_BOT_OFF;
        end else begin
            top_drive_a_n_o  <= ~top_on_w[`BCG_PH_A]; // [R6]
            top_drive_b_n_o  <= ~top_on_w[`BCG_PH_B]; // [R6]
            top_drive_c_n_o  <= ~top_on_w[`BCG_PH_C]; // [R6]
            bottom_drive_a_o <= bot_on_w[`BCG_PH_A];
            bottom_drive_b_o <= bot_on_w[`BCG_PH_B];
            bottom_drive_c_o <= bot_on_w[`BCG_PH_C];
        end
    end

endmodule

// [verif/bcg_hall_model.sv]
// Rotor sensor model: turns a rotor step into a sensor code
`timescale 1ns/1ns
module bcg_hall_model (
    input  wire       clk_sys_i,
    input  wire [2:0] step_i,
    input  wire       sel60_i,
    output reg  [2:0] code_o
);
    // Steps 6 and 7 give the invalid codes: 101 and 010 at 60 degrees, open or shorted line (111, 000) at 120
    always @(posedge clk_sys_i) begin
        case (step_i)
            3'h0: code_o <= 3'h4;
            3'h1: code_o <= 3'h6;
            3'h2: code_o <= sel60_i ? 3'h7 : 3'h2;
            3'h3: code_o <= 3'h3;
            3'h4: code_o <= 3'h1;
            3'h5: code_o <= sel60_i ? 3'h0 : 3'h5;
            3'h6: code_o <= sel60_i ? 3'h5 : 3'h7;
            default: code_o <= sel60_i ? 3'h2 : 3'h0;
        endcase
    end
endmodule

// [verif/bcg_chk.sv]
// Concurrent checks on the commutation gate ports
`timescale 1ns/1ns
module bcg_chk (
    input logic clk_sys_i, rstn_i, osc_cycle_start_i, ramp_above_cmd_i, current_over_i, enable_i,
    input logic vcc_undervolt_i, ref_undervolt_i, pwm_latch_o, limit_latch_o,
    input logic top_drive_a_n_o, top_drive_b_n_o, top_drive_c_n_o,
    input logic bottom_drive_a_o, bottom_drive_b_o, bottom_drive_c_o
);
    wire [2:0] top_n = {top_drive_a_n_o, top_drive_b_n_o, top_drive_c_n_o};
    wire [2:0] bot   = {bottom_drive_a_o, bottom_drive_b_o, bottom_drive_c_o};
    wire       off   = (top_n == 3'h7) && (bot == 3'h0);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Eight samples cover the synchroniser plus latch and output stages
    a_pair_legal: assert property ($onehot0(~top_n) && $onehot0(bot) && !(~top_n & bot))
        else $error("illegal drive pair");
    a_coast_off: assert property (!enable_i [*8] |-> off)
        else $error("drives on while disabled");
    a_uv_off: assert property ((vcc_undervolt_i || ref_undervolt_i) [*8] |-> off)
        else $error("drives on in undervoltage");
    a_limit_off: assert property (current_over_i [*8] |-> off && !limit_latch_o)
        else $error("drives on in current limit");
    a_pwm_clear: assert property (ramp_above_cmd_i [*8] |-> !pwm_latch_o && bot == 3'h0)
        else $error("bottom drive on past compare");
    a_start_set: assert property ((osc_cycle_start_i && !ramp_above_cmd_i && !current_over_i) [*8]
        |-> pwm_latch_o && limit_latch_o)
        else $error("latches not set at cycle start");
    a_bot_gated: assert property ($rose(|bot) |-> $past(pwm_latch_o && limit_latch_o))
        else $error("bottom drive without latches");
    a_one_pulse: assert property (!osc_cycle_start_i [*8] |-> !$rose(pwm_latch_o) && !$rose(limit_latch_o))
        else $error("latch set without cycle start");
endmodule
bind bcg_commutation_gate bcg_chk u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .osc_cycle_start_i(osc_cycle_start_i), .ramp_above_cmd_i(ramp_above_cmd_i), .current_over_i(current_over_i),
    .enable_i(enable_i), .vcc_undervolt_i(vcc_undervolt_i), .ref_undervolt_i(ref_undervolt_i),
    .pwm_latch_o(pwm_latch_o), .limit_latch_o(limit_latch_o), .top_drive_a_n_o(top_drive_a_n_o),
    .top_drive_b_n_o(top_drive_b_n_o), .top_drive_c_n_o(top_drive_c_n_o), .bottom_drive_a_o(bottom_drive_a_o),
    .bottom_drive_b_o(bottom_drive_b_o), .bottom_drive_c_o(bottom_drive_c_o));

// [verif/tb.sv]
// Testbench for the commutation and drive-gating block
`timescale 1ns/1ns
module tb;
    reg        clk_sys_i = 1'b0;
    reg        rstn_i = 1'b0;
    reg        sel = 1'b1, fwd = 1'b1, en = 1'b1, osc = 1'b0, ramp = 1'b0, cur = 1'b0, uvv = 1'b0, uvr = 1'b0;
    reg  [2:0] step = 3'h0;
    wire [2:0] code, top_n, bot;
    integer    error_cnt = 0, checks_done = 0, k;
    bcg_hall_model u_hall (.clk_sys_i(clk_sys_i), .step_i(step), .sel60_i(sel), .code_o(code));
    bcg_commutation_gate u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .rotor_sensor_a_i(code[2]),
        .rotor_sensor_b_i(code[1]), .rotor_sensor_c_i(code[0]), .phase_60_sel_i(sel), .forward_i(fwd),
        .enable_i(en), .osc_cycle_start_i(osc), .ramp_above_cmd_i(ramp), .current_over_i(cur),
        .vcc_undervolt_i(uvv), .ref_undervolt_i(uvr), .top_drive_a_n_o(top_n[2]), .top_drive_b_n_o(top_n[1]),
        .top_drive_c_n_o(top_n[0]), .bottom_drive_a_o(bot[2]), .bottom_drive_b_o(bot[1]),
        .bottom_drive_c_o(bot[0]), .pwm_latch_o(), .limit_latch_o());
    task wait_n(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Start held long enough to pass the agreement filter, then released
    task start_cycle;
        begin
            osc <= 1'b1;
            wait_n(9);
            osc <= 1'b0;
            wait_n(9);
        end
    endtask
    task check(input [5:0] exp);
        begin
            #1;
            checks_done = checks_done + 1;
            if ({top_n, bot} !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t drives %h expected %h", $time, {top_n, bot}, exp);
            end
            @(posedge clk_sys_i);
        end
    endtask
    function [5:0] exp_drv(input [2:0] st, input f);
        reg [2:0] t, b;
        begin
            case (st)
                3'h0: {t, b} = 6'h21;
                3'h1: {t, b} = 6'h11;
                3'h2: {t, b} = 6'h14;
                3'h3: {t, b} = 6'h0c;
                3'h4: {t, b} = 6'h0a;
                3'h5: {t, b} = 6'h22;
                default: {t, b} = 6'h00;
            endcase
            if (!f) {t, b} = {b, t};
            exp_drv = {~t, b};
        end
    endfunction
    task final_report;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        final_report;
    end
    initial begin
        wait_n(3);
        rstn_i <= 1'b1;
        for (k = 0; k < 32; k = k + 1) begin
            sel <= k[4];
            fwd <= k[3];
            step <= k[2:0];
            start_cycle;
            check(exp_drv(k[2:0], k[3]));
        end
        $display("decode test done");
        step <= 3'h0;
        start_cycle;
        check(exp_drv(3'h0, 1'b1));
        ramp <= 1'b1;
        wait_n(10);
        check(6'h18);
        ramp <= 1'b0;
        wait_n(10);
        check(6'h18);
        start_cycle;
        check(exp_drv(3'h0, 1'b1));
        cur <= 1'b1;
        wait_n(10);
        check(6'h38);
        cur <= 1'b0;
        wait_n(10);
        check(6'h38);
        $display("pwm and limit test done");
        for (k = 0; k < 3; k = k + 1) begin
            en <= (k != 0);
            uvv <= (k == 1);
            uvr <= (k == 2);
            // A fresh cycle start sets both latches, so only the protection input can hold drives off
            start_cycle;
            check(6'h38);
            en <= 1'b1;
            uvv <= 1'b0;
            uvr <= 1'b0;
            start_cycle;
            check(exp_drv(3'h0, 1'b1));
        end
        $display("protection test done");
        final_report;
    end
endmodule
